// [logic/dlpll_pkg.sv]
// Package of offsets, field positions and constants for the loop block
package dlpll_pkg;
   // Register addresses carried in the low five bits of a serial word
   localparam logic [4:0] ADDR_CLEANER_LOCK = 5'h19;
   localparam logic [4:0] ADDR_SYNTH_LOOP = 5'h1a;
   localparam logic [4:0] ADDR_CLEANER_LOOP = 5'h1b;
   localparam logic [4:0] ADDR_LOOP_DIV = 5'h1c;
   localparam logic [4:0] ADDR_SYNTH_CAL = 5'h1d;
   localparam logic [4:0] ADDR_SYNTH_FB = 5'h1e;
   localparam int ADDR_BASE = 25;  // First stored register
   localparam int NUM_CFG = 6;     // Stored registers 25 to 30
   // Serial word layout
   localparam int WORD_W = 32;
   localparam int ADDR_W = 5;
   // Field positions
   localparam int LOCK_CNT_LSB = 6;    // Both lock counts, 14 bits
   localparam int LOCK_CNT_W = 14;
   localparam int SWIN_LSB = 30;       // Synth lock window, 2 bits
   localparam int DOUBLER_BIT = 29;
   localparam int POL_BIT = 28;
   localparam int CUR_LSB = 26;        // Pump current, 2 bits
   localparam int FLOAT_BIT = 5;
   localparam int PRE1_LSB = 22;
   localparam int PRE0_LSB = 20;
   localparam int CREF_LSB = 6;        // Cleaner reference divider
   localparam int CREF_W = 14;
   localparam int SREF_LSB = 20;       // Synth reference divider
   localparam int SREF_W = 12;
   localparam int CFB_LSB = 6;         // Cleaner feedback divider
   localparam int CFB_W = 14;
   localparam int BAND_LSB = 24;       // Oscillator band, 3 bits
   localparam int FAST_BIT = 23;
   localparam int SFB_LSB = 5;         // Both synth feedback dividers
   localparam int SFB_W = 18;
   // Value of every stored register after reset
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   // Pump currents in microamps
   localparam logic [11:0] SCUR_0 = 12'h064;  // 100
   localparam logic [11:0] SCUR_1 = 12'h190;  // 400
   localparam logic [11:0] SCUR_2 = 12'h640;  // 1600
   localparam logic [11:0] SCUR_3 = 12'hc80;  // 3200
   localparam logic [11:0] CCUR_0 = 12'h064;  // 100
   localparam logic [11:0] CCUR_1 = 12'h0c8;  // 200
   localparam logic [11:0] CCUR_2 = 12'h190;  // 400
   localparam logic [11:0] CCUR_3 = 12'h640;  // 1600
   // Calibration run time and clock rate
   localparam int CLK_PERIOD_NS = 20;
   localparam int CAL_TIME_NS = 100000;
   localparam int CAL_CYCLES = CAL_TIME_NS / CLK_PERIOD_NS;
endpackage

// [logic/dlpll_event_div.sv]
// Event divider: one output pulse per DIV input events
`timescale 1ns/1ps
module dlpll_event_div #(
   parameter int W = 14
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ev_in,            // One-cycle input event
   input wire logic [W-1:0] div_in,   // Divide value, zero stops output
   output logic pulse_out             // Registered output event
);
   // Width check
   if (W < 1 || W > 24) begin : g_bad_w
      $error("dlpll_event_div: W out of range");
   end

   logic [W-1:0] cnt_r; // Events seen since last output

   // Count events and wrap at the divide value
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r <= '0;
         pulse_out <= 1'b0;
      end else begin
         pulse_out <= 1'b0;
         if (div_in == '0) begin
            // Invalid code, hold quiet
            cnt_r <= '0;
         end else if (ev_in) begin
            if (cnt_r >= div_in - W'(1)) begin
               cnt_r <= '0;
               pulse_out <= 1'b1;
            end else begin
               cnt_r <= cnt_r + W'(1);
            end
         end
      end
   end
endmodule

// [logic/dlpll_top.sv]
// Dual loop configuration registers, dividers and digital lock detect
`timescale 1ns/1ps
module dlpll_top #(
   parameter int CAL_CYCLES = dlpll_pkg::CAL_CYCLES
) (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic SER_DATA_IN,          // Serial data, MSB first
   input wire logic SER_CLK_IN,           // Serial shift clock level
   input wire logic SER_LATCH_IN,         // Latch enable level
   input wire logic INT_VCO_MODE_IN,      // Internal oscillator in use
   input wire logic INPUT_SEL_IN,         // Active clock input
   input wire logic INPUT0_CLK_IN,        // Clock input 0 level
   input wire logic INPUT1_CLK_IN,        // Clock input 1 level
   input wire logic CLEANER_FB_CLK_IN,    // Cleaner feedback level
   input wire logic SYNTH_REF_CLK_IN,     // Synth reference level
   input wire logic SYNTH_FB_CLK_IN,      // Prescaled oscillator level
   input wire logic CLEANER_PD_CYCLE_IN,  // Cleaner compare strobe
   input wire logic CLEANER_IN_WIN_IN,    // Cleaner error within window
   input wire logic SYNTH_PD_CYCLE_IN,    // Synth compare strobe
   input wire logic SYNTH_IN_WIN_IN,      // Synth error within window
   output logic CLEANER_REF_PULSE_OUT,
   output logic CLEANER_FB_PULSE_OUT,
   output logic SYNTH_REF_PULSE_OUT,
   output logic SYNTH_FB_PULSE_OUT,
   output logic CLEANER_LOCK_OUT,
   output logic SYNTH_LOCK_OUT,
   output logic [1:0] CLEANER_WINDOW_OUT,
   output logic [1:0] SYNTH_WINDOW_OUT,
   output logic CLEANER_PUMP_POL_OUT,
   output logic CLEANER_PUMP_OE_OUT,
   output logic [11:0] CLEANER_PUMP_UA_OUT,
   output logic SYNTH_PUMP_POL_OUT,
   output logic SYNTH_PUMP_OE_OUT,
   output logic [11:0] SYNTH_PUMP_UA_OUT,
   output logic [2:0] OSC_BAND_OUT,
   output logic FAST_COMPARE_OUT,
   output logic CAL_BUSY_OUT,
   output logic SYNC_PULSE_OUT
);
   // Calibration length check
   if (CAL_CYCLES < 8 || CAL_CYCLES > 1048575) begin : g_bad_cal
      $error("dlpll_top: CAL_CYCLES out of range");
   end

   logic [31:0] shift_r;          // Serial shift register
   logic sclk_q_r;                // Previous shift clock level
   logic latch_q_r;               // Previous latch level
   logic [31:0] cfg_r [dlpll_pkg::NUM_CFG]; // Stored registers
   logic wr_r;                    // Word latched this cycle
   logic [31:0] wr_word_r;        // Word latched
   logic [19:0] cal_cnt_r;        // Calibration cycles left
   logic [4:0] clk_q_r;           // Previous clock input levels
   logic [1:0] pd_cycle;          // Compare strobes per loop
   logic [1:0] in_win;            // Window flags per loop
   logic [13:0] lock_tgt [2];     // Lock targets per loop
   logic [13:0] lock_cnt_r [2];   // Lock counters per loop
   logic [1:0] lock_r;            // Lock flags per loop
   logic [1:0] pre_ev;            // Raw input edge events
   logic [1:0] pre_pulse;         // Prescaled input events
   logic [3:0] pre_div [2];       // Prescaler divide values
   logic cref_ev;                 // Selected prescaled event
   logic cfb_ev;
   logic sref_ev;
   logic sfb_ev;
   logic [17:0] sfb_div;          // Active synth feedback divide

   // Shift on clock rise, write on latch rise
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         shift_r <= 32'h0000_0000;
         sclk_q_r <= 1'b0;
         latch_q_r <= 1'b0;
         wr_r <= 1'b0;
         wr_word_r <= 32'h0000_0000;
      end else begin
         sclk_q_r <= SER_CLK_IN;
         latch_q_r <= SER_LATCH_IN;
         wr_r <= SER_LATCH_IN && !latch_q_r;
         if (SER_LATCH_IN && !latch_q_r) begin
            wr_word_r <= shift_r;
         end
         if (SER_CLK_IN && !sclk_q_r) begin
            shift_r <= {shift_r[30:0], SER_DATA_IN};
         end
      end
   end

   // Register file, one entry per stored address
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         for (int i = 0; i < dlpll_pkg::NUM_CFG; i++) begin
            cfg_r[i] <= dlpll_pkg::CFG_RESET;
         end
      end else if (wr_r) begin
         for (int i = 0; i < dlpll_pkg::NUM_CFG; i++) begin
            if (wr_word_r[4:0] == 5'(dlpll_pkg::ADDR_BASE + i)) begin
               cfg_r[i] <= wr_word_r;
            end
         end
      end
   end

   // Calibration timer started by a register 30 write while the internal oscillator is in use
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cal_cnt_r <= 20'h00000;
         SYNC_PULSE_OUT <= 1'b0;
      end else begin
         SYNC_PULSE_OUT <= 1'b0;
         if (wr_r && wr_word_r[4:0] == dlpll_pkg::ADDR_SYNTH_FB &&
             INT_VCO_MODE_IN) begin
            cal_cnt_r <= 20'(CAL_CYCLES);
            SYNC_PULSE_OUT <= 1'b1;
         end else if (cal_cnt_r != 20'h00000) begin
            cal_cnt_r <= cal_cnt_r - 20'h00001;
         end
      end
   end
   assign CAL_BUSY_OUT = (cal_cnt_r != 20'h00000);

   // Clock input edge history
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         clk_q_r <= 5'h00;
      end else begin
         clk_q_r <= {SYNTH_FB_CLK_IN, SYNTH_REF_CLK_IN, CLEANER_FB_CLK_IN,
                     INPUT1_CLK_IN, INPUT0_CLK_IN};
      end
   end

   // Rising edges, and both edges of the synth reference when doubled
   assign pre_ev[0] = INPUT0_CLK_IN && !clk_q_r[0];
   assign pre_ev[1] = INPUT1_CLK_IN && !clk_q_r[1];
   assign cfb_ev = CLEANER_FB_CLK_IN && !clk_q_r[2];
   assign sref_ev = cfg_r[1][dlpll_pkg::DOUBLER_BIT] ?
                    (SYNTH_REF_CLK_IN != clk_q_r[3]) :
                    (SYNTH_REF_CLK_IN && !clk_q_r[3]);
   assign sfb_ev = SYNTH_FB_CLK_IN && !clk_q_r[4];

   // Prescaler codes select 1, 2, 4 or 8
   assign pre_div[0] = 4'h1 << cfg_r[2][dlpll_pkg::PRE0_LSB +: 2];
   assign pre_div[1] = 4'h1 << cfg_r[2][dlpll_pkg::PRE1_LSB +: 2];

   // One prescaler per clock input
   for (genvar p = 0; p < 2; p++) begin : g_pre
      dlpll_event_div #(.W(4)) u_pre (
         .clk_in(CLK_IN),
         .rst_in(RST_IN),
         .ev_in(pre_ev[p]),
         .div_in(pre_div[p]),
         .pulse_out(pre_pulse[p])
      );
   end
   assign cref_ev = INPUT_SEL_IN ? pre_pulse[1] : pre_pulse[0];

   // Cleaner reference divider
   dlpll_event_div #(.W(dlpll_pkg::CREF_W)) u_cref (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .ev_in(cref_ev),
      .div_in(cfg_r[2][dlpll_pkg::CREF_LSB +: dlpll_pkg::CREF_W]),
      .pulse_out(CLEANER_REF_PULSE_OUT)
   );

   // Cleaner feedback divider
   dlpll_event_div #(.W(dlpll_pkg::CFB_W)) u_cfb (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .ev_in(cfb_ev),
      .div_in(cfg_r[3][dlpll_pkg::CFB_LSB +: dlpll_pkg::CFB_W]),
      .pulse_out(CLEANER_FB_PULSE_OUT)
   );

   // Synth reference divider
   dlpll_event_div #(.W(dlpll_pkg::SREF_W)) u_sref (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .ev_in(sref_ev),
      .div_in(cfg_r[3][dlpll_pkg::SREF_LSB +: dlpll_pkg::SREF_W]),
      .pulse_out(SYNTH_REF_PULSE_OUT)
   );

   // Calibration divide stands in while calibration runs
   assign sfb_div = CAL_BUSY_OUT ?
      cfg_r[4][dlpll_pkg::SFB_LSB +: dlpll_pkg::SFB_W] :
      cfg_r[5][dlpll_pkg::SFB_LSB +: dlpll_pkg::SFB_W];

   // Synth feedback divider
   dlpll_event_div #(.W(dlpll_pkg::SFB_W)) u_sfb (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .ev_in(sfb_ev),
      .div_in(sfb_div),
      .pulse_out(SYNTH_FB_PULSE_OUT)
   );

   // Loop 0 is the cleaner, loop 1 the synth
   assign pd_cycle = {SYNTH_PD_CYCLE_IN, CLEANER_PD_CYCLE_IN};
   assign in_win = {SYNTH_IN_WIN_IN, CLEANER_IN_WIN_IN};
   assign lock_tgt[0] = cfg_r[0][dlpll_pkg::LOCK_CNT_LSB +: 14];
   assign lock_tgt[1] = cfg_r[1][dlpll_pkg::LOCK_CNT_LSB +: 14];

   // Lock counters: count in-window cycles, clear on a miss
   for (genvar l = 0; l < 2; l++) begin : g_lock
      always_ff @(posedge CLK_IN or posedge RST_IN) begin
         if (RST_IN) begin
            lock_cnt_r[l] <= 14'h0000;
            lock_r[l] <= 1'b0;
         end else if (pd_cycle[l]) begin
            if (!in_win[l]) begin
               lock_cnt_r[l] <= 14'h0000;
               lock_r[l] <= 1'b0;
            end else if (lock_tgt[l] == 14'h0000) begin
               // Reserved target never locks
               lock_r[l] <= 1'b0;
            end else if (lock_cnt_r[l] >= lock_tgt[l] - 14'h0001) begin
               // Compare against target minus one so lock sets on the strobe that brings the count to target
               lock_cnt_r[l] <= lock_tgt[l];
               lock_r[l] <= 1'b1;
            end else begin
               lock_cnt_r[l] <= lock_cnt_r[l] + 14'h0001;
            end
         end
      end
   end
   assign CLEANER_LOCK_OUT = lock_r[0];
   assign SYNTH_LOCK_OUT = lock_r[1];

   // Window codes passed to the analog comparators
   assign CLEANER_WINDOW_OUT = 2'h0;
   assign SYNTH_WINDOW_OUT = cfg_r[1][dlpll_pkg::SWIN_LSB +: 2];

   // Pump controls, float drops drive and current
   assign SYNTH_PUMP_POL_OUT = cfg_r[1][dlpll_pkg::POL_BIT];
   assign SYNTH_PUMP_OE_OUT = !cfg_r[1][dlpll_pkg::FLOAT_BIT];
   assign CLEANER_PUMP_POL_OUT = cfg_r[2][dlpll_pkg::POL_BIT];
   assign CLEANER_PUMP_OE_OUT = !cfg_r[2][dlpll_pkg::FLOAT_BIT];

   // Current decode per loop
   always_comb begin
      SYNTH_PUMP_UA_OUT = 12'h000;
      CLEANER_PUMP_UA_OUT = 12'h000;
      if (SYNTH_PUMP_OE_OUT) begin
         case (cfg_r[1][dlpll_pkg::CUR_LSB +: 2])
            2'h0: SYNTH_PUMP_UA_OUT = dlpll_pkg::SCUR_0;
            2'h1: SYNTH_PUMP_UA_OUT = dlpll_pkg::SCUR_1;
            2'h2: SYNTH_PUMP_UA_OUT = dlpll_pkg::SCUR_2;
            default: SYNTH_PUMP_UA_OUT = dlpll_pkg::SCUR_3;
         endcase
      end
      if (CLEANER_PUMP_OE_OUT) begin
         case (cfg_r[2][dlpll_pkg::CUR_LSB +: 2])
            2'h0: CLEANER_PUMP_UA_OUT = dlpll_pkg::CCUR_0;
            2'h1: CLEANER_PUMP_UA_OUT = dlpll_pkg::CCUR_1;
            2'h2: CLEANER_PUMP_UA_OUT = dlpll_pkg::CCUR_2;
            default: CLEANER_PUMP_UA_OUT = dlpll_pkg::CCUR_3;
         endcase
      end
   end

   // Settings handed to calibration and compare logic
   assign OSC_BAND_OUT = cfg_r[4][dlpll_pkg::BAND_LSB +: 3];
   assign FAST_COMPARE_OUT = cfg_r[4][dlpll_pkg::FAST_BIT];

   // Checks
   a_cleaner_lock_count: assert property (
      @(posedge CLK_IN) disable iff (RST_IN)
      $rose(lock_r[0]) |-> lock_cnt_r[0] == lock_tgt[0] &&
                           lock_tgt[0] != 14'h0000)
      else $error("cleaner lock rose before count reached");
   a_synth_lock_count: assert property (
      @(posedge CLK_IN) disable iff (RST_IN)
      $rose(lock_r[1]) |-> $past(lock_cnt_r[1]) + 14'h0001 >= lock_tgt[1])
      else $error("synth lock rose early");
   a_synth_count_step: assert property (
      @(posedge CLK_IN) disable iff (RST_IN)
      pd_cycle[1] && in_win[1] && lock_cnt_r[1] + 14'h0001 < lock_tgt[1]
      |=> lock_cnt_r[1] == $past(lock_cnt_r[1]) + 14'h0001)
      else $error("synth counter did not step");
   a_miss_clears: assert property (
      @(posedge CLK_IN) disable iff (RST_IN)
      (pd_cycle & ~in_win) != 2'h0
      |=> (lock_r & $past(pd_cycle) & ~$past(in_win)) == 2'h0)
      else $error("miss did not clear lock");
   a_float_write: assert property (
      @(posedge CLK_IN) disable iff (RST_IN)
      wr_r && wr_word_r[4:0] == dlpll_pkg::ADDR_SYNTH_LOOP && wr_word_r[5]
      |=> !SYNTH_PUMP_OE_OUT && SYNTH_PUMP_UA_OUT == 12'h000)
      else $error("synth float did not idle pump");
   a_cleaner_current: assert property (
      @(posedge CLK_IN) disable iff (RST_IN)
      CLEANER_PUMP_OE_OUT && cfg_r[2][27:26] == 2'h1
      |-> CLEANER_PUMP_UA_OUT == 12'h0c8)
      else $error("cleaner current code 1 not 200");
   a_cal_start_sync: assert property (
      @(posedge CLK_IN) disable iff (RST_IN)
      wr_r && wr_word_r[4:0] == 5'h1e && INT_VCO_MODE_IN
      |=> SYNC_PULSE_OUT ##1 (!SYNC_PULSE_OUT && CAL_BUSY_OUT) [*7])
      else $error("calibration did not start with one sync");
   a_cal_divider: assert property (
      @(posedge CLK_IN) disable iff (RST_IN)
      CAL_BUSY_OUT |-> sfb_div == cfg_r[4][22:5])
      else $error("calibration divide not in use");
   a_doubler_fall: assert property (
      @(posedge CLK_IN) disable iff (RST_IN)
      cfg_r[1][29] && $fell(SYNTH_REF_CLK_IN) |-> sref_ev)
      else $error("doubler missed falling edge");
endmodule

// [verif/testbench.sv]
// Self-checking bench for the dual loop configuration and lock block
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;                 // Bench clock, 50 MHz
   logic rst = 1'b1;                 // Active high reset
   logic sd = 1'b0, sc = 1'b0, sl = 1'b0;  // Serial data, clock, latch
   logic vco = 1'b0, isel = 1'b0;    // Oscillator mode, input select
   logic in0 = 1'b0, in1 = 1'b0, cfb = 1'b0, sref = 1'b0, sfb = 1'b0;
   logic cpd = 1'b0, cwin = 1'b0, spd = 1'b0, swin = 1'b0;
   logic crp, cfp, srp, sfp, clk_l, syn_l, cpol, coe, spol, soe, fast;
   logic cbusy, sync;
   logic [1:0] cwo, swo;
   logic [11:0] cua, sua;
   logic [2:0] band;
   int error_cnt = 0;                // Mismatches seen
   int checked = 0;                  // Comparisons made
   int n_cr, n_cf, n_sr, n_sf, n_sync, n_busy;  // Output event counts
   logic [11:0] scur [4];            // Synth pump current per code
   logic [11:0] ccur [4];            // Cleaner pump current per code

   // Clock generator
   always #10 clk = ~clk;

   dlpll_top #(.CAL_CYCLES(64)) uut (
      .CLK_IN(clk), .RST_IN(rst), .SER_DATA_IN(sd), .SER_CLK_IN(sc),
      .SER_LATCH_IN(sl), .INT_VCO_MODE_IN(vco), .INPUT_SEL_IN(isel),
      .INPUT0_CLK_IN(in0), .INPUT1_CLK_IN(in1), .CLEANER_FB_CLK_IN(cfb),
      .SYNTH_REF_CLK_IN(sref), .SYNTH_FB_CLK_IN(sfb),
      .CLEANER_PD_CYCLE_IN(cpd), .CLEANER_IN_WIN_IN(cwin),
      .SYNTH_PD_CYCLE_IN(spd), .SYNTH_IN_WIN_IN(swin),
      .CLEANER_REF_PULSE_OUT(crp), .CLEANER_FB_PULSE_OUT(cfp),
      .SYNTH_REF_PULSE_OUT(srp), .SYNTH_FB_PULSE_OUT(sfp),
      .CLEANER_LOCK_OUT(clk_l), .SYNTH_LOCK_OUT(syn_l),
      .CLEANER_WINDOW_OUT(cwo), .SYNTH_WINDOW_OUT(swo),
      .CLEANER_PUMP_POL_OUT(cpol), .CLEANER_PUMP_OE_OUT(coe),
      .CLEANER_PUMP_UA_OUT(cua), .SYNTH_PUMP_POL_OUT(spol),
      .SYNTH_PUMP_OE_OUT(soe), .SYNTH_PUMP_UA_OUT(sua),
      .OSC_BAND_OUT(band), .FAST_COMPARE_OUT(fast),
      .CAL_BUSY_OUT(cbusy), .SYNC_PULSE_OUT(sync)
   );

   // Count one-cycle output events and busy cycles where outputs are settled
   always @(negedge clk) begin
      n_cr += (crp === 1'b1);
      n_cf += (cfp === 1'b1);
      n_sr += (srp === 1'b1);
      n_sf += (sfp === 1'b1);
      n_sync += (sync === 1'b1);
      n_busy += (cbusy === 1'b1);
   end

   // Compare one value, count it, report a difference
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Clear the event counters between tests
   task automatic clr();
      @(negedge clk);
      {n_cr, n_cf, n_sr, n_sf, n_sync, n_busy} = '0;
   endtask

   // Shift one word MSB first, then latch it and let the write land
   task automatic wr(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         @(negedge clk);
         sd = w[i];
         sc = 1'b0;
         @(negedge clk);
         sc = 1'b1;
      end
      @(negedge clk);
      sl = 1'b1;
      @(negedge clk);
      sl = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   // Send n rising edges on a chosen event input, two cycles per level
   task automatic evs(input int sel, input int n);
      repeat (n) begin
         for (int lv = 1; lv >= 0; lv--) begin
            case (sel)
               0: in0 = lv[0];
               1: in1 = lv[0];
               2: cfb = lv[0];
               3: sref = lv[0];
               default: sfb = lv[0];
            endcase
            repeat (2) @(negedge clk);
         end
      end
      repeat (4) @(negedge clk);
   endtask

   // One compare strobe on the synth (s=1) or cleaner (s=0) detector
   task automatic strobe(input bit s, input bit win);
      @(negedge clk);
      if (s) {spd, swin} = {1'b1, win};
      else {cpd, cwin} = {1'b1, win};
      @(negedge clk);
      {spd, cpd} = 2'b00;
      repeat (2) @(negedge clk);
   endtask

   // Lock needs n in-window strobes and drops on a miss
   task automatic lock_seq(input bit s, input int n);
      for (int i = 1; i <= n; i++) begin
         strobe(s, 1'b1);
         check(s ? syn_l : clk_l, (i == n));
      end
      strobe(s, 1'b1);
      check(s ? syn_l : clk_l, 1'b1);
      strobe(s, 1'b0);
      check(s ? syn_l : clk_l, 1'b0);
      strobe(s, 1'b1);
      check(s ? syn_l : clk_l, (n == 1));
   endtask

   // Closing verdict
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      #1000000;
      error_cnt++;
      report_and_stop();
   end

   // Main test sequence
   initial begin
      scur = '{dlpll_pkg::SCUR_0, dlpll_pkg::SCUR_1, dlpll_pkg::SCUR_2,
               dlpll_pkg::SCUR_3};
      ccur = '{dlpll_pkg::CCUR_0, dlpll_pkg::CCUR_1, dlpll_pkg::CCUR_2,
               dlpll_pkg::CCUR_3};
      repeat (4) @(negedge clk);
      rst = 1'b0;
      check({syn_l, clk_l, cbusy}, 3'h0);
      check({soe, coe, sua, cua}, {2'h3, scur[0], ccur[0]});
      $display("test reset done");
      // Pump current codes, float override and polarity
      for (int c = 0; c < 4; c++) begin
         wr({2'h2, 1'b0, 1'b1, c[1:0], 6'h0, 14'h3, 1'b0, 5'h1a});
         check({swo, spol, soe, sua}, {2'h2, 2'h3, scur[c]});
         wr({2'h2, 1'b0, 1'b1, c[1:0], 6'h0, 14'h3, 1'b1, 5'h1a});
         check({soe, sua}, 13'h0);
         wr({3'h0, c[0], c[1:0], 6'h0, 14'h1, 1'b0, 5'h1b});
         check({cpol, coe, cua}, {c[0], 1'b1, ccur[c]});
         wr({3'h0, c[0], c[1:0], 6'h0, 14'h1, 1'b1, 5'h1b});
         check({coe, cua}, 13'h0);
      end
      $display("test pump done");
      // Unmapped addresses are ignored
      wr(32'hffff_ffe5);
      wr(32'hffff_ffff);
      check({swo, spol, soe, coe}, {2'h2, 1'b1, 1'b0, 1'b0});
      $display("test unmapped done");
      // Lock detect on both loops
      wr({2'h2, 4'h1, 6'h0, 14'h3, 1'b0, 5'h1a});  // Window code 2
      lock_seq(1'b1, 3);
      wr({12'h0, 14'h2, 1'b0, 5'h19});  // Nonzero count
      lock_seq(1'b0, 2);
      wr({12'h0, 14'h1, 1'b0, 5'h19});  // Nonzero count
      lock_seq(1'b0, 1);
      check(cwo, 2'h0);
      $display("test lock done");
      // Prescalers in front of the cleaner reference divider
      wr({8'h0, 2'h3, 2'h1, 14'h2, 1'b0, 5'h1b});
      wr({12'h2, 14'h3, 1'b0, 5'h1c});  // Divide 2, no doubler needed
      clr();
      evs(0, 8);
      check(n_cr, 2);
      isel = 1'b1;
      clr();
      evs(1, 16);
      check(n_cr, 1);
      clr();
      evs(2, 6);
      check(n_cf, 2);
      // Synth reference with and without the doubler
      clr();
      evs(3, 4);
      check(n_sr, 2);
      wr({2'h2, 1'b1, 3'h0, 6'h0, 14'h3, 1'b0, 5'h1a});
      clr();
      evs(3, 4);
      check(n_sr, 4);
      $display("test dividers done");
      // Band, fast compare and calibration divider substitution
      wr({5'h0, 3'h4, 1'b1, 18'h4, 5'h1d});  // Unequal, zero-delay use
      check({band, fast}, 4'h9);
      vco = 1'b1;  // Synth polarity is negative here
      clr();
      wr({9'h0, 18'h2, 5'h1e});
      check(cbusy, 1'b1);
      evs(4, 8);
      check(n_sf, 2);
      for (int i = 0; i < 100 && cbusy !== 1'b0; i++) @(negedge clk);
      check(n_sync, 1);
      check(n_busy, 64);
      clr();
      evs(4, 4);
      check(n_sf, 2);
      vco = 1'b0;
      clr();
      wr({9'h0, 18'h2, 5'h1e});
      repeat (4) @(negedge clk);
      check(n_sync, 0);
      check(n_busy, 0);
      $display("test calibration done");
      report_and_stop();
   end
endmodule
